// *** afc_cfg.svh ***
// constants for the converter output format and test pattern control block
// Operation
// - output is two's complement by default, offset binary when programmed
// - 16-bit codes: 7FFF/0000/8000 two's complement, FFFF/8000/0000 offset binary
// - patterns follow decimation, replace its output; channel A controls both
// - ramp steps by the low 5 pattern bits, output takes accumulator bits 17:2
// - custom pattern mode outputs bits 17:2 of the fixed pattern register value
// - normal mode outputs 16-bit samples with one sampling clock latency
// - global power-down by serial command or high power-down pin
// - power-down requests act only while the sampling clock runs
// - global power-down always takes the core; buffers may be masked
// - unprogrammed defaults: downconverter bypassed, two's complement, external ref
// - serial word is 24 bits under low select, committed on 24th edge
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
`define AFC_ADDR_IF_CFG 12'h007
`define AFC_ADDR_PDN_CTL 12'h008
`define AFC_ADDR_PDN_LANE 12'h009
`define AFC_ADDR_PDN_MASK 12'h00D
`define AFC_ADDR_REF_CFG 12'h00E
`define AFC_ADDR_FUSE 12'h013
`define AFC_ADDR_CPAT_LO 12'h014
`define AFC_ADDR_CPAT_MID 12'h015
`define AFC_ADDR_TPAT 12'h016
`define AFC_ADDR_FRAME_CLOCK_CTL 12'h019
`define AFC_ADDR_MAPPER 12'h01B
`define AFC_ADDR_FPAT_LO 12'h020
`define AFC_ADDR_FPAT_MID 12'h021
`define AFC_ADDR_FPAT_HI 12'h022
`define AFC_ADDR_DDC_CTL 12'h024
`define AFC_ADDR_DEC_CFG 12'h025
`define AFC_ADDR_MIX_CFG 12'h026
`define AFC_ADDR_ORD_A 12'h027
`define AFC_ADDR_ORD_B 12'h02E
`define AFC_ADDR_FMT_A 12'h08F
`define AFC_ADDR_FMT_B 12'h092
`define AFC_RST_CFG 8'h00
`define AFC_PDN_FIXED 8'h02
`define AFC_BIT_PDN_GLOBAL 0
`define AFC_BIT_PDN_REFAMP 4
`define AFC_BIT_PDN_CLKBUF 5
`define AFC_BIT_MASK_REFAMP 2
`define AFC_BIT_MASK_CLKBUF 3
`define AFC_BIT_FUSE_LD 0
`define AFC_BIT_DDC_EN 1
`define AFC_BIT_FMT_OB 0
`define AFC_BIT_REF_INT 3
`define AFC_TPAT_A_LSB 2
`define AFC_MIX_UPD_MASK 8'h22
`define AFC_WORD_BITS 5'd24
`define AFC_ADDR_BITS 5'd16
`endif

// *** afc_ctrl.sv ***
// converter control: configuration registers, output format, test patterns, power-down
`timescale 1ns/1ps
`include "afc_cfg.svh"
module afc_ctrl
  import afc_pkg::*;
(
  input wire logic ref_clk, // sampling clock, 40 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic serial_select_n, // serial port select pin, active low
  input wire logic serial_clk, // serial port clock pin
  input wire logic sdio_in, // serial data pin, input side
  output logic sdio_out, // serial data pin, output side
  output logic sdio_oe_n, // serial data pin driven when low
  input wire logic powerdown_sync_pin, // global power-down pin, active high
  input wire afc_pkg::afc_pair_t core_sample, // two's complement core samples
  input wire afc_pkg::afc_pair_t ddc_sample, // downconverter output samples
  output afc_pkg::afc_pair_t serial_lvds_output, // formatted sample word to lanes
  output logic out_valid, // sample word valid, low in power-down
  output logic pdn_core, // converter core power-down
  output logic pdn_clkbuf, // clock buffer power-down
  output logic pdn_refamp, // reference amplifier power-down
  output logic [5:0] pdn_lanes, // per-driver output power-down
  output logic ref_internal, // internal reference selected
  output logic fuse_load, // fuse trim load strobe level
  output logic digital_downconverter_en, // downconverter in path
  output logic [7:0] dec_cfg, // decimation configuration
  output logic [7:0] mix_cfg, // committed mixer configuration
  output logic [7:0] if_cfg, // output interface and bit mapper
  output logic [7:0] mapper_cfg, // bit mapper resolution
  output logic [7:0] frame_clock_cfg, // frame clock control
  output logic [19:0] frame_clock_pattern, // frame clock pattern
  output logic [1:0] q_delay // q-delay bits, channel b and a
);
  import afc_pkg::*;

  // byte slots
  localparam int NREG = 21;
  // interface, power
  localparam logic [4:0] I_IF = 5'd0;
  localparam logic [4:0] I_PDN = 5'd1;
  localparam logic [4:0] I_LANE = 5'd2;
  localparam logic [4:0] I_MASK = 5'd3;
  localparam logic [4:0] I_REF = 5'd4;

  // fuse, pattern
  localparam logic [4:0] I_FUSE = 5'd5;
  localparam logic [4:0] I_CPL = 5'd6;
  localparam logic [4:0] I_CPM = 5'd7;
  localparam logic [4:0] I_TPAT = 5'd8;

  // frame clock, mapper
  localparam logic [4:0] I_FRAME_CLOCK = 5'd9;
  localparam logic [4:0] I_MAP = 5'd10;
  localparam logic [4:0] I_FPL = 5'd11;
  localparam logic [4:0] I_FPM = 5'd12;
  localparam logic [4:0] I_FPH = 5'd13;

  // downconverter, mixer, order
  localparam logic [4:0] I_DDC = 5'd14;
  localparam logic [4:0] I_DEC = 5'd15;
  localparam logic [4:0] I_MIX = 5'd16;
  localparam logic [4:0] I_ORDA = 5'd17;
  localparam logic [4:0] I_ORDB = 5'd18;

  // output format
  localparam logic [4:0] I_FMTA = 5'd19;
  localparam logic [4:0] I_FMTB = 5'd20;

  // maps a register address to its slot; bit 5 flags a hit
  function automatic logic [5:0] afc_slot(input logic [11:0] addr);
    logic [5:0] s;
    s = 6'h00;
    unique case (addr)
      `AFC_ADDR_IF_CFG: s = {1'b1, I_IF};
      `AFC_ADDR_PDN_CTL: s = {1'b1, I_PDN};
      `AFC_ADDR_PDN_LANE: s = {1'b1, I_LANE};
      `AFC_ADDR_PDN_MASK: s = {1'b1, I_MASK};
      `AFC_ADDR_REF_CFG: s = {1'b1, I_REF};
      `AFC_ADDR_FUSE: s = {1'b1, I_FUSE};
      `AFC_ADDR_CPAT_LO: s = {1'b1, I_CPL};
      `AFC_ADDR_CPAT_MID: s = {1'b1, I_CPM};
      `AFC_ADDR_TPAT: s = {1'b1, I_TPAT};
      `AFC_ADDR_FRAME_CLOCK_CTL: s = {1'b1, I_FRAME_CLOCK};
      `AFC_ADDR_MAPPER: s = {1'b1, I_MAP};
      `AFC_ADDR_FPAT_LO: s = {1'b1, I_FPL};
      `AFC_ADDR_FPAT_MID: s = {1'b1, I_FPM};
      `AFC_ADDR_FPAT_HI: s = {1'b1, I_FPH};
      `AFC_ADDR_DDC_CTL: s = {1'b1, I_DDC};
      `AFC_ADDR_DEC_CFG: s = {1'b1, I_DEC};
      `AFC_ADDR_MIX_CFG: s = {1'b1, I_MIX};
      `AFC_ADDR_ORD_A: s = {1'b1, I_ORDA};
      `AFC_ADDR_ORD_B: s = {1'b1, I_ORDB};
      `AFC_ADDR_FMT_A: s = {1'b1, I_FMTA};
      `AFC_ADDR_FMT_B: s = {1'b1, I_FMTB};
      default: s = 6'h00;
    endcase
    return s;
  endfunction

  // offset binary is two's complement with the sign bit inverted
  function automatic logic [15:0] afc_fmt(input logic [15:0] v, input logic ob);
    return ob ? {~v[15], v[14:0]} : v;
  endfunction

  // pin synchronisers: select idles high, clock and data low
  logic [3:0] pins_f;
  afc_pin_sync #(.W(4), .INIT(4'h1)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({powerdown_sync_pin, sdio_in, serial_clk, serial_select_n}),
    .sync_out(pins_f)
  );

  // serial control port
  logic wr_stb;
  afc_wr_t wr;
  logic [11:0] rd_addr;
  logic [7:0] rd_data_reg, rd_data_next;
  logic sdo, sdo_oe_n;

  afc_spi_slave u_spi (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sel_n(pins_f[0]),
    .sclk(pins_f[1]),
    .sdi(pins_f[2]),
    .rd_data(rd_data_reg),
    .rd_addr(rd_addr),
    .wr_stb(wr_stb),
    .wr(wr),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n)
  );

  // configuration bytes and their write path
  logic [7:0] cfg_reg [NREG];
  logic [7:0] cfg_next [NREG];
  logic [5:0] wslot, rslot;
  assign wslot = afc_slot(wr.addr);
  assign rslot = afc_slot(rd_addr);

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    // mapped write replaces its byte
    if (wr_stb && wslot[5]) begin
      cfg_next[wslot[4:0]] = wr.data;
    end
    // power-down bit 1 reads one
    cfg_next[I_PDN] = cfg_next[I_PDN] | `AFC_PDN_FIXED;
  end

  // reset leaves every byte cleared: bypass, two's complement, external ref
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        cfg_reg[i] <= `AFC_RST_CFG;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // readback byte, unmapped addresses read zero
  always_comb begin
    rd_data_next = rslot[5] ? cfg_reg[rslot[4:0]] : 8'h00;
  end

  // mixer setting commits when a write clears update bits that were set
  logic [7:0] mix_reg, mix_next;
  always_comb begin
    mix_next = mix_reg;
    if (wr_stb && wslot[5] && (wslot[4:0] == I_MIX)
        && ((cfg_reg[I_MIX] & `AFC_MIX_UPD_MASK) != 8'h00)
        && ((wr.data & `AFC_MIX_UPD_MASK) == 8'h00)) begin
      mix_next = wr.data;
    end
  end

  // power-down: command or pin, taken on the running sampling clock
  logic gpdn;
  logic pdn_core_reg, pdn_core_next;
  logic pdn_clkbuf_reg, pdn_clkbuf_next;
  logic pdn_refamp_reg, pdn_refamp_next;
  logic [5:0] pdn_lanes_reg, pdn_lanes_next;
  assign gpdn = cfg_reg[I_PDN][`AFC_BIT_PDN_GLOBAL] | pins_f[3];

  always_comb begin
    pdn_core_next = gpdn;
    pdn_clkbuf_next = cfg_reg[I_PDN][`AFC_BIT_PDN_CLKBUF]
                      | (gpdn & ~cfg_reg[I_MASK][`AFC_BIT_MASK_CLKBUF]);
    pdn_refamp_next = cfg_reg[I_PDN][`AFC_BIT_PDN_REFAMP]
                      | (gpdn & ~cfg_reg[I_MASK][`AFC_BIT_MASK_REFAMP]);
    pdn_lanes_next = cfg_reg[I_LANE][5:0];
  end

  // sample path: source select, format, pattern override
  afc_pat_t pat_mode;
  logic [17:0] ramp_reg, ramp_next;
  logic [17:0] fixed_pattern_value;
  logic ddc_on;
  afc_pair_t src, fmt;
  afc_pair_t out_reg, out_next;
  logic valid_reg, valid_next;

  assign pat_mode = afc_pat_t'(cfg_reg[I_TPAT][`AFC_TPAT_A_LSB +: 3]);
  assign fixed_pattern_value = {cfg_reg[I_TPAT][1:0], cfg_reg[I_CPM], cfg_reg[I_CPL]};
  assign ddc_on = cfg_reg[I_DDC][`AFC_BIT_DDC_EN];

  always_comb begin
    src = ddc_on ? ddc_sample : core_sample;
    fmt.a = afc_fmt(src.a, cfg_reg[I_FMTA][`AFC_BIT_FMT_OB]);
    fmt.b = afc_fmt(src.b, cfg_reg[I_FMTB][`AFC_BIT_FMT_OB]);
    ramp_next = 18'h00000;
    out_next = fmt;
    unique case (pat_mode)
      AFC_PAT_RAMP: begin
        // step sits in the low bits; the output drops the two lowest accumulator bits 1:0
        ramp_next = ramp_reg + {13'h0000, fixed_pattern_value[4:0]};
        out_next.a = ramp_reg[17:2];
        out_next.b = ramp_reg[17:2];
      end
      AFC_PAT_CUSTOM: begin
        out_next.a = fixed_pattern_value[17:2];
        out_next.b = fixed_pattern_value[17:2];
      end
      AFC_PAT_OFF: begin
        out_next = fmt;
      end
      default: begin
        out_next = fmt;
      end
    endcase

    // power-down blanks the output
    valid_next = ~pdn_core_reg;
    if (pdn_core_reg) begin
      out_next = '0;
    end
  end

  // registers for control outputs and the sample path
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // readback, mixer
      rd_data_reg <= 8'h00;
      mix_reg <= `AFC_RST_CFG;
      // power-down
      pdn_core_reg <= 1'b0;
      pdn_clkbuf_reg <= 1'b0;
      pdn_refamp_reg <= 1'b0;
      pdn_lanes_reg <= 6'h00;
      // sample path
      ramp_reg <= 18'h00000;
      out_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      mix_reg <= mix_next;
      pdn_core_reg <= pdn_core_next;
      pdn_clkbuf_reg <= pdn_clkbuf_next;
      pdn_refamp_reg <= pdn_refamp_next;
      pdn_lanes_reg <= pdn_lanes_next;

      ramp_reg <= ramp_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
    end
  end

  // outputs, all straight from flip-flops
  // serial data pin
  assign sdio_out = sdo;
  assign sdio_oe_n = sdo_oe_n;

  // sample stream
  assign serial_lvds_output = out_reg;
  assign out_valid = valid_reg;

  // power-down
  assign pdn_core = pdn_core_reg;
  assign pdn_clkbuf = pdn_clkbuf_reg;
  assign pdn_refamp = pdn_refamp_reg;
  assign pdn_lanes = pdn_lanes_reg;

  // configuration
  assign ref_internal = cfg_reg[I_REF][`AFC_BIT_REF_INT];
  assign fuse_load = cfg_reg[I_FUSE][`AFC_BIT_FUSE_LD];
  assign digital_downconverter_en = ddc_on;
  assign dec_cfg = cfg_reg[I_DEC];
  assign mix_cfg = mix_reg;
  assign if_cfg = cfg_reg[I_IF];
  assign mapper_cfg = cfg_reg[I_MAP];
  assign frame_clock_cfg = cfg_reg[I_FRAME_CLOCK];
  assign frame_clock_pattern = {cfg_reg[I_FPH][3:0], cfg_reg[I_FPM], cfg_reg[I_FPL]};
  assign q_delay = {cfg_reg[I_ORDB][3], cfg_reg[I_ORDA][3]};
endmodule

// *** afc_ctrl_sva.sv ***
// assertion checker for the converter control block
`timescale 1ns/1ps
module afc_ctrl_sva (
  input wire logic ref_clk, // sampling clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic serial_select_n, // serial select pin
  input wire logic powerdown_sync_pin, // power-down pin
  input wire afc_pkg::afc_pair_t serial_lvds_output, // formatted samples
  input wire logic out_valid, // sample valid
  input wire logic pdn_core, // core power-down
  input wire logic sdio_oe_n, // serial data driven when low
  input wire logic ref_internal, // internal reference
  input wire logic digital_downconverter_en, // downconverter in path
  input wire logic [7:0] dec_cfg, // decimation byte
  input wire logic [7:0] if_cfg, // interface byte
  input wire logic [7:0] mapper_cfg, // mapper byte
  input wire logic [19:0] frame_clock_pattern // frame clock pattern
);
  import afc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // power-down by pin, core off and samples invalid
  pin_pdn_a: assert property (powerdown_sync_pin [*8] |-> pdn_core && !out_valid)
    else $error("pin power-down not applied");
  pdn_zero_a: assert property (pdn_core [*3] |-> serial_lvds_output == '0)
    else $error("samples not zero in power-down");
  pdn_valid_a: assert property ($rose(pdn_core) |-> ##[0:2] !out_valid)
    else $error("valid stays high in power-down");
  rst_default_a: assert property (disable iff (1'b0) !rst_b |=>
    dec_cfg == 8'h00 && !digital_downconverter_en && !ref_internal && !out_valid)
    else $error("reset defaults wrong");
  // serial port: device drives only inside a selected word
  oe_select_a: assert property ($fell(sdio_oe_n) |-> !serial_select_n)
    else $error("data pin driven while unselected");
  sel_idle_a: assert property (serial_select_n [*6] |-> sdio_oe_n)
    else $error("data pin driven after select rise");
  cfg_word_a: assert property ($changed({if_cfg, mapper_cfg, dec_cfg}) |-> !serial_select_n)
    else $error("config changed outside a word");
  pat_still_a: assert property (serial_select_n [*8] |->
    $stable(frame_clock_pattern) && $stable(digital_downconverter_en))
    else $error("config moved while unselected");
  cover property (powerdown_sync_pin ##8 !out_valid);
  cover property ($fell(sdio_oe_n));
  cover property ($changed(dec_cfg));
endmodule
bind afc_ctrl afc_ctrl_sva afc_ctrl_sva_inst (.ref_clk, .rst_b, .serial_select_n,
  .powerdown_sync_pin, .serial_lvds_output, .out_valid, .pdn_core, .sdio_oe_n, .ref_internal,
  .digital_downconverter_en, .dec_cfg, .if_cfg, .mapper_cfg, .frame_clock_pattern);

// *** afc_host.sv ***
// host controller model driving the serial control port
`timescale 1ns/1ps
module afc_host (
  input wire logic ref_clk, // sampling clock
  output logic serial_select_n, // select, active low
  output logic serial_clk, // serial clock, still between words
  output logic sdio_in, // resolved data wire
  input wire logic sdio_out, // device data
  input wire logic sdio_oe_n // device drives when low
);
  logic drv_bit;
  logic drv_en;
  logic float_bit;
  initial begin
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    drv_bit = 1'b0;
    drv_en = 1'b0;
    float_bit = 1'b0;
  end
  // undriven wire toggles so a stale level is never read as data
  always @(posedge ref_clk) float_bit <= ~float_bit;
  assign sdio_in = !sdio_oe_n ? sdio_out : (drv_en ? drv_bit : float_bit);
  // one 24-bit word msb first, six cycles per clock phase, data read on rises
  task automatic xfer(input logic [23:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    serial_select_n <= 1'b0;
    drv_en <= 1'b1;
    for (int i = 23; i >= 0; i--) begin
      repeat (6) @(posedge ref_clk);
      serial_clk <= 1'b0;
      drv_en <= (i > 7) || !w[23];
      drv_bit <= w[i];
      repeat (6) @(posedge ref_clk);
      if (i < 8) rd = {rd[6:0], sdio_in};
      serial_clk <= 1'b1;
    end
    repeat (12) @(posedge ref_clk);
    serial_select_n <= 1'b1;
    drv_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
    serial_clk <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic write(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] rd;
    xfer({4'h0, a, d}, rd);
  endtask
  task automatic read(input logic [11:0] a, output logic [7:0] d);
    xfer({4'h8, a, 8'h00}, d);
  endtask
endmodule

// *** afc_pin_sync.sv ***
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module afc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk, // sampling clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [W-1:0] async_in, // pins from outside the clock domain
  output logic [W-1:0] sync_out // filtered level
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [W-1:0] s1_next, s2_next, s3_next, out_next;

  // next values: shift chain, accept bits where two and three agree
  always_comb begin
    s1_next = async_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule

// *** afc_pkg.sv ***
// shared types for the converter output format and test pattern control block
package afc_pkg;
  typedef struct packed {
    logic [15:0] a; // channel a sample
    logic [15:0] b; // channel b sample
  } afc_pair_t;
  typedef struct packed {
    logic [11:0] addr; // register address
    logic [7:0] data; // write data
  } afc_wr_t;
  typedef enum logic [2:0] {
    AFC_PAT_OFF = 3'b000,
    AFC_PAT_CUSTOM = 3'b001,
    AFC_PAT_RAMP = 3'b010
  } afc_pat_t;
  typedef enum logic [1:0] {
    AFC_SPI_IDLE = 2'b00,
    AFC_SPI_SHIFT = 2'b01
  } afc_spi_state_t;
endpackage

// *** afc_spi_slave.sv ***
// serial control port: 24-bit words, write commit and register readback
`timescale 1ns/1ps
`include "afc_cfg.svh"
module afc_spi_slave
  import afc_pkg::*;
(
  input wire logic ref_clk, // sampling clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic sel_n, // filtered serial select, active low
  input wire logic sclk, // filtered serial clock
  input wire logic sdi, // filtered serial data in
  input wire logic [7:0] rd_data, // readback byte, registered by the host logic
  output logic [11:0] rd_addr, // readback address
  output logic wr_stb, // one-cycle write commit
  output afc_pkg::afc_wr_t wr, // committed write
  output logic sdo, // serial data out
  output logic sdo_oe_n // sdio driven when low
);
  import afc_pkg::*;
  afc_spi_state_t st_reg, st_next;
  logic [23:0] sh_reg, sh_next;
  logic [4:0] cnt_reg, cnt_next;
  logic sclk_d_reg, sclk_d_next;
  logic rd_reg, rd_next;
  logic [7:0] tx_reg, tx_next;
  logic oe_n_reg, oe_n_next;
  logic wr_stb_reg, wr_stb_next;
  afc_wr_t wr_reg, wr_next;
  logic [11:0] rd_addr_reg, rd_addr_next;
  logic rise, fall;
  logic [23:0] word;

  assign rise = sclk & ~sclk_d_reg;
  assign fall = ~sclk & sclk_d_reg;
  assign word = {sh_reg[22:0], sdi};

  // word assembly, commit on the 24th rising edge, readback on falling edges
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    sclk_d_next = sclk;
    rd_next = rd_reg;
    tx_next = tx_reg;
    oe_n_next = oe_n_reg;
    wr_stb_next = 1'b0;
    wr_next = wr_reg;
    rd_addr_next = rd_addr_reg;
    unique case (st_reg)
      AFC_SPI_IDLE: begin
        cnt_next = 5'd0;
        oe_n_next = 1'b1;
        rd_next = 1'b0;
        if (!sel_n) begin
          st_next = AFC_SPI_SHIFT;
        end
      end
      AFC_SPI_SHIFT: begin
        if (sel_n) begin
          st_next = AFC_SPI_IDLE; // partial words are dropped
          oe_n_next = 1'b1;
        end else if (rise) begin
          sh_next = word;
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == `AFC_ADDR_BITS - 5'd1) begin
            rd_next = word[15] & (word[14:12] == 3'h0);
            rd_addr_next = word[11:0];
          end
          if (cnt_reg == `AFC_WORD_BITS - 5'd1) begin
            cnt_next = 5'd0;
            rd_next = 1'b0;
            oe_n_next = 1'b1;
            if (!word[23] && (word[22:20] == 3'h0)) begin
              wr_stb_next = 1'b1;
              wr_next.addr = word[19:8];
              wr_next.data = word[7:0];
            end
          end
        end else if (fall && rd_reg) begin
          if (cnt_reg == `AFC_ADDR_BITS) begin
            tx_next = rd_data;
            oe_n_next = 1'b0;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
      end
      default: begin
        st_next = AFC_SPI_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_reg <= AFC_SPI_IDLE;
      sh_reg <= 24'h000000;
      cnt_reg <= 5'd0;
      sclk_d_reg <= 1'b0;
      rd_reg <= 1'b0;
      tx_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      wr_stb_reg <= 1'b0;
      wr_reg <= '0;
      rd_addr_reg <= 12'h000;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      sclk_d_reg <= sclk_d_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      oe_n_reg <= oe_n_next;
      wr_stb_reg <= wr_stb_next;
      wr_reg <= wr_next;
      rd_addr_reg <= rd_addr_next;
    end
  end

  assign rd_addr = rd_addr_reg;
  assign wr_stb = wr_stb_reg;
  assign wr = wr_reg;
  assign sdo = tx_reg[7];
  assign sdo_oe_n = oe_n_reg;
endmodule

// *** tb_afc_ctrl.sv ***
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb_afc_ctrl;
  import afc_pkg::*;
  logic ref_clk, rst_b, powerdown_sync_pin, serial_select_n, serial_clk, sdio_in;
  logic sdio_out, sdio_oe_n, out_valid, pdn_core, pdn_clkbuf, pdn_refamp, ref_internal;
  logic fuse_load, digital_downconverter_en;
  logic [5:0] pdn_lanes;
  logic [7:0] dec_cfg, mix_cfg, if_cfg, mapper_cfg, frame_clock_cfg, rd;
  logic [19:0] frame_clock_pattern;
  logic [1:0] q_delay;
  afc_pair_t core_sample, ddc_sample, serial_lvds_output;
  int miscompares, total_checks, cycles;
  logic [15:0] vin [3] = '{16'h7FFF, 16'h0000, 16'h8000};
  logic [15:0] vob [3] = '{16'hFFFF, 16'h8000, 16'h0000};
  afc_ctrl afc_ctrl_inst (.ref_clk, .rst_b, .serial_select_n, .serial_clk, .sdio_in, .sdio_out,
    .sdio_oe_n, .powerdown_sync_pin, .core_sample, .ddc_sample, .serial_lvds_output, .out_valid,
    .pdn_core, .pdn_clkbuf, .pdn_refamp, .pdn_lanes, .ref_internal, .fuse_load,
    .digital_downconverter_en, .dec_cfg, .mix_cfg, .if_cfg, .mapper_cfg, .frame_clock_cfg,
    .frame_clock_pattern, .q_delay);
  afc_host afc_host_inst (.ref_clk, .serial_select_n, .serial_clk, .sdio_in, .sdio_out,
    .sdio_oe_n);
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // drive one sample pair and compare the registered output one cycle later
  task automatic check_pair(input afc_pair_t in, input afc_pair_t exp, input string what);
    @(posedge ref_clk);
    core_sample <= in;
    ddc_sample <= ~in;
    @(posedge ref_clk);
    #1 check_val(serial_lvds_output, exp, what);
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check_val({dec_cfg, if_cfg, mix_cfg, mapper_cfg}, 32'h0, "config defaults");
    check_val({digital_downconverter_en, ref_internal, pdn_core, out_valid}, 4'h1, "flags");
    afc_host_inst.read(12'h008, rd);
    check_val(rd, 8'h02, "power-down byte read");
    afc_host_inst.read(12'h0FF, rd);
    check_val(rd, 8'h00, "unmapped read");
    for (int i = 0; i < 3; i++) check_pair({vin[i], vin[2-i]}, {vin[i], vin[2-i]}, "twos");
  endtask
  task automatic t_format;
    afc_host_inst.write(12'h08F, 8'h01);
    for (int i = 0; i < 3; i++) check_pair({vin[i], vin[i]}, {vob[i], vin[i]}, "ob a");
    afc_host_inst.write(12'h092, 8'h01);
    for (int i = 0; i < 3; i++) check_pair({vin[i], vin[i]}, {vob[i], vob[i]}, "ob ab");
    afc_host_inst.write(12'h08F, 8'h00);
    afc_host_inst.write(12'h092, 8'h00);
    check_pair({vin[0], vin[2]}, {vin[0], vin[2]}, "back to twos");
  endtask
  task automatic t_config;
    afc_host_inst.write(12'h007, 8'h6C);
    afc_host_inst.write(12'h013, 8'h01);
    check_val(fuse_load, 1'b1, "fuse load set");
    repeat (40000) @(posedge ref_clk);
    afc_host_inst.write(12'h013, 8'h00);
    afc_host_inst.write(12'h019, 8'h80);
    afc_host_inst.write(12'h01B, 8'h88);
    afc_host_inst.write(12'h020, 8'hFF);
    afc_host_inst.write(12'h021, 8'hFF);
    afc_host_inst.write(12'h022, 8'h0F);
    afc_host_inst.write(12'h024, 8'h06);
    afc_host_inst.write(12'h025, 8'h30);
    afc_host_inst.write(12'h027, 8'h08);
    afc_host_inst.write(12'h02E, 8'h08);
    afc_host_inst.write(12'h026, 8'hAA);
    check_val(mix_cfg, 8'h00, "mixer held before toggle");
    afc_host_inst.write(12'h026, 8'h88);
    check_val({if_cfg, fuse_load, frame_clock_cfg, mapper_cfg}, 25'hD88088, "cfg");
    check_val({frame_clock_pattern, digital_downconverter_en, dec_cfg}, 29'h1FFFFF30, "dec");
    check_val({q_delay, mix_cfg}, 10'h388, "q delay and mixer");
    check_pair({vin[0], vin[1]}, ~{vin[0], vin[1]}, "downconverter path");
  endtask
  task automatic t_pattern;
    afc_pair_t prev;
    afc_host_inst.write(12'h014, 8'h34);
    afc_host_inst.write(12'h015, 8'h12);
    afc_host_inst.write(12'h016, 8'h46);
    check_pair({vin[0], vin[1]}, {16'h848D, 16'h848D}, "custom pattern");
    check_pair({vin[2], vin[0]}, {16'h848D, 16'h848D}, "custom held");
    afc_host_inst.write(12'h014, 8'h04);
    afc_host_inst.write(12'h015, 8'h00);
    afc_host_inst.write(12'h016, 8'h28);
    #1 prev = serial_lvds_output;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1 check_val(16'(serial_lvds_output.a - prev.a), 16'h0001, "ramp step");
      check_val(serial_lvds_output.b, serial_lvds_output.a, "ramp on b");
      prev = serial_lvds_output;
    end
    afc_host_inst.write(12'h016, 8'h00);
    check_pair({vin[1], vin[0]}, ~{vin[1], vin[0]}, "pattern off");
  endtask
  task automatic t_power;
    @(posedge ref_clk);
    powerdown_sync_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 check_val({pdn_core, out_valid, pdn_clkbuf, pdn_refamp}, 4'hB, "pin pdn");
    check_val(serial_lvds_output, 32'h0, "zero output");
    @(posedge ref_clk);
    powerdown_sync_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 check_val({pdn_core, out_valid}, 2'b01, "pin wake");
    afc_host_inst.write(12'h00D, 8'h08);
    afc_host_inst.write(12'h009, 8'h3F);
    afc_host_inst.write(12'h008, 8'h03);
    check_val({pdn_core, pdn_clkbuf, pdn_refamp, pdn_lanes}, 9'h17F, "serial pdn masked");
    afc_host_inst.write(12'h008, 8'h02);
    afc_host_inst.write(12'h00D, 8'h00);
    check_val({pdn_core, out_valid}, 2'b01, "serial wake");
    afc_host_inst.write(12'h00E, 8'h08);
    afc_host_inst.write(12'h008, 8'h32);
    check_val({pdn_core, pdn_clkbuf, pdn_refamp, ref_internal}, 4'h7, "own pdn");
  endtask
  initial begin
    rst_b = 1'b0;
    powerdown_sync_pin = 1'b0;
    core_sample = '0;
    ddc_sample = '0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    t_reset;
    t_format;
    t_config;
    t_pattern;
    t_power;
    t_reset;
    final_report;
  end
endmodule
